// >>> hw/lsu_addr_unit.sv
/*
 lsu_addr_unit: decode and address generation for pc-relative loads and for register-offset,
 unprivileged and multiple-register loads and stores. Assumes the front end holds
 the operand values steady in the cycle of START, the register file supplies store
 data for the index on MEM_REG, and memory returns loads right-aligned on MEM_ACK.
*/
// The implementer's own choices: the address map and the plain strobed port.
`default_nettype none
module lsu_addr_unit #(
  parameter int REGS = 16 // architectural register count
) (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic START,
  input wire logic [3:0] OPCODE,
  input wire logic [2:0] XTYPE,
  input wire logic PRIV_MODE,
  input wire logic [31:0] BASE_VAL,
  input wire logic [31:0] OFFSET_VAL,
  input wire logic [31:0] PC_VAL,
  input wire logic [1:0] SHIFT_AMT,
  input wire logic [12:0] IMM_OFFSET,
  input wire logic [3:0] XFER_REG,
  input wire logic [3:0] XFER_REG2,
  input wire logic [3:0] BASE_REG,
  input wire logic [15:0] REG_LIST,
  input wire logic WRITEBACK,
  input wire logic MEM_ACK,
  input wire logic [31:0] MEM_RDATA,
  output logic BUSY,
  output logic MEM_REQ,
  output logic MEM_WRITE,
  output logic [31:0] MEM_ADDR,
  output logic [1:0] MEM_SIZE,
  output logic MEM_UNPRIV,
  output logic [3:0] MEM_REG,
  output logic RF_WE,
  output logic [3:0] RF_WADDR,
  output logic [31:0] RF_WDATA,
  output logic BRANCH,
  output logic [31:0] BRANCH_TARGET,
  output logic BASE_WE,
  output logic [3:0] BASE_WADDR,
  output logic [31:0] BASE_WDATA,
  output logic FLAGS_WE,
  output logic UNDEF,
  output logic DONE
);
  // ==========================================================
  // elaboration check
  if (REGS != 16) begin : g_chk
    $error("lsu_addr_unit supports sixteen registers only");
  end

  // ==========================================================
  // helpers
  // picks the next register: lowest for ascending, highest for descending
  function automatic logic [3:0] pick(input logic [15:0] l, input logic db);
    logic [3:0] k;
    k = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (db) begin
        if (l[i]) k = 4'(i); // last hit is the highest
      end else if (l[15 - i]) begin
        k = 4'(15 - i); // last hit is the lowest
      end
    end
    return k;
  endfunction

  // widens fetched data to 32 bits per transfer type
  function automatic logic [31:0] extend(input logic [31:0] d, input logic [2:0] ty);
    case (ty)
      lsu_pkg::ty_byte: extend = {24'h0, d[7:0]};
      lsu_pkg::ty_half: extend = {16'h0, d[15:0]};
      lsu_pkg::ty_signed_byte_type: extend = {{24{d[7]}}, d[7:0]};
      lsu_pkg::ty_signed_halfword_type: extend = {{16{d[15]}}, d[15:0]};
      default: extend = d;
    endcase
  endfunction

  // ==========================================================
  // decode of the presented operation
  logic d_load; // operation reads memory
  logic d_multi; // multiple-register transfer
  logic d_db; // decrement before
  logic d_pair; // two-word pc-relative load
  logic d_unpriv; // unprivileged variant
  logic d_pcrel; // pc-relative single
  logic d_regoff; // register-offset form
  logic d_legal; // encoding accepted
  logic d_signed; // signed transfer type
  logic [12:0] imm_mag; // magnitude of the signed immediate
  logic [31:0] d_addr; // first access address
  logic [3:0] d_reg; // first register moved
  logic [1:0] d_size; // access size

  // one case per addressing form; aliases fall into the plain mode decode
  always_comb begin
    d_load = 1'b0;
    d_multi = 1'b0;
    d_db = 1'b0;
    d_pair = 1'b0;
    d_unpriv = 1'b0;
    d_pcrel = 1'b0;
    d_regoff = 1'b0;
    d_signed = (XTYPE == lsu_pkg::ty_signed_byte_type) ||
               (XTYPE == lsu_pkg::ty_signed_halfword_type);
    imm_mag = IMM_OFFSET[12] ? 13'(-IMM_OFFSET) : IMM_OFFSET;
    case (lsu_pkg::opcode_t'(OPCODE))
      lsu_pkg::op_load_register: begin
        d_load = 1'b1;
        d_regoff = 1'b1;
      end
      lsu_pkg::op_store_register: d_regoff = 1'b1;
      lsu_pkg::op_load_register_unpriv: begin
        d_load = 1'b1;
        d_unpriv = 1'b1;
      end
      lsu_pkg::op_store_register_unpriv: d_unpriv = 1'b1;
      lsu_pkg::op_load_register_pc: begin
        d_load = 1'b1;
        d_pcrel = 1'b1;
      end
      lsu_pkg::op_load_register_pair: begin
        d_load = 1'b1;
        d_pair = 1'b1;
      end
      // ascending loads: default mode and its pop alias
      lsu_pkg::op_load_multiple, lsu_pkg::op_load_multiple_increment_after,
      lsu_pkg::op_pop_full_descending_alias: begin
        d_load = 1'b1;
        d_multi = 1'b1;
      end
      lsu_pkg::op_load_multiple_decrement_before,
      lsu_pkg::op_pop_empty_ascending_alias: begin
        d_load = 1'b1;
        d_multi = 1'b1;
        d_db = 1'b1;
      end
      lsu_pkg::op_store_multiple, lsu_pkg::op_store_multiple_increment_after,
      lsu_pkg::op_push_empty_ascending_alias: d_multi = 1'b1;
      default: begin // decrement-before stores and their push alias
        d_multi = 1'b1;
        d_db = 1'b1;
      end
    endcase
    // signed stores are not decoded; empty lists and out-of-range offsets refused
    d_legal = 1'b1;
    if (!d_load && d_signed) d_legal = 1'b0;
    if (d_unpriv && (imm_mag > lsu_pkg::UNPRIV_MAX || IMM_OFFSET[12])) d_legal = 1'b0;
    if (d_pcrel && imm_mag > lsu_pkg::PC_SINGLE_MAX) d_legal = 1'b0;
    if (d_pair && imm_mag > lsu_pkg::PC_PAIR_MAX) d_legal = 1'b0;
    if (d_multi && REG_LIST == 16'h0) d_legal = 1'b0;
    // first address per form
    if (d_regoff) begin
      d_addr = BASE_VAL + (OFFSET_VAL << SHIFT_AMT);
    end else if (d_unpriv) begin
      d_addr = BASE_VAL + {24'h0, IMM_OFFSET[7:0]};
    end else if (d_pcrel || d_pair) begin
      d_addr = PC_VAL + {{19{IMM_OFFSET[12]}}, IMM_OFFSET};
    end else begin
      d_addr = BASE_VAL;
    end
    d_reg = d_multi ? pick(REG_LIST, d_db) : XFER_REG;
    // pairs and lists always move whole words
    case (lsu_pkg::xtype_t'(XTYPE))
      lsu_pkg::ty_byte, lsu_pkg::ty_signed_byte_type: d_size = lsu_pkg::SZ_BYTE;
      lsu_pkg::ty_half, lsu_pkg::ty_signed_halfword_type: d_size = lsu_pkg::SZ_HALF;
      default: d_size = lsu_pkg::SZ_WORD;
    endcase
    if (d_multi || d_pair) d_size = lsu_pkg::SZ_WORD;
  end

  // ==========================================================
  // sequencer state
  lsu_pkg::state_t state_r, state_nxt;
  logic [31:0] addr_r, addr_nxt; // current access address
  logic [3:0] reg_r, reg_nxt; // register being moved
  logic [15:0] list_r, list_nxt; // registers still to move after reg_r
  logic pair_r, pair_nxt; // second word of a pair pending
  logic [3:0] rt2_r, rt2_nxt; // second pair register
  logic load_r, load_nxt;
  logic multi_r, multi_nxt;
  logic db_r, db_nxt;
  logic wb_r, wb_nxt;
  logic unpriv_r, unpriv_nxt;
  logic [2:0] ty_r, ty_nxt;
  logic [1:0] size_r, size_nxt;
  logic [3:0] base_reg_r, base_reg_nxt;
  // result strobes, one cycle each
  logic rf_we_r, rf_we_nxt;
  logic [31:0] rf_wdata_r, rf_wdata_nxt;
  logic [3:0] rf_waddr_r, rf_waddr_nxt;
  logic branch_r, branch_nxt;
  logic [31:0] target_r, target_nxt;
  logic base_we_r, base_we_nxt;
  logic [31:0] base_wdata_r, base_wdata_nxt;
  logic undef_r, undef_nxt;
  logic done_r, done_nxt;

  // next-state logic; a new operation is only taken while idle
  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    reg_nxt = reg_r;
    list_nxt = list_r;
    pair_nxt = pair_r;
    rt2_nxt = rt2_r;
    load_nxt = load_r;
    multi_nxt = multi_r;
    db_nxt = db_r;
    wb_nxt = wb_r;
    unpriv_nxt = unpriv_r;
    ty_nxt = ty_r;
    size_nxt = size_r;
    base_reg_nxt = base_reg_r;
    rf_we_nxt = 1'b0;
    rf_waddr_nxt = rf_waddr_r;
    rf_wdata_nxt = rf_wdata_r;
    branch_nxt = 1'b0;
    target_nxt = target_r;
    base_we_nxt = 1'b0;
    base_wdata_nxt = base_wdata_r;
    undef_nxt = 1'b0;
    done_nxt = 1'b0;
    case (state_r)
      lsu_pkg::st_idle: begin
        if (START && d_legal) begin
          state_nxt = lsu_pkg::st_xfer;
          addr_nxt = d_addr;
          reg_nxt = d_reg;
          list_nxt = d_multi ? (REG_LIST & ~(16'h0001 << d_reg)) : 16'h0;
          pair_nxt = d_pair;
          rt2_nxt = XFER_REG2;
          load_nxt = d_load;
          multi_nxt = d_multi;
          db_nxt = d_db;
          wb_nxt = d_multi & WRITEBACK;
          unpriv_nxt = d_unpriv | ~PRIV_MODE;
          ty_nxt = (d_multi || d_pair) ? lsu_pkg::ty_word : XTYPE;
          size_nxt = d_size;
          base_reg_nxt = BASE_REG;
        end else if (START) begin
          undef_nxt = 1'b1;
        end
      end
      lsu_pkg::st_xfer: begin
        if (MEM_ACK) begin
          // loads to the pc branch instead of writing the register file
          if (load_r && reg_r == lsu_pkg::PC_NUM) begin
            branch_nxt = 1'b1;
            target_nxt = {MEM_RDATA[31:1], 1'b0};
          end else if (load_r) begin
            rf_we_nxt = 1'b1;
            rf_waddr_nxt = reg_r;
            rf_wdata_nxt = extend(MEM_RDATA, ty_r);
          end
          if (pair_r) begin
            pair_nxt = 1'b0;
            reg_nxt = rt2_r;
            addr_nxt = addr_r + lsu_pkg::WORD_STEP;
          end else if (list_r != 16'h0) begin
            reg_nxt = pick(list_r, db_r);
            list_nxt = list_r & ~(16'h0001 << pick(list_r, db_r));
            addr_nxt = db_r ? addr_r - lsu_pkg::WORD_STEP
                            : addr_r + lsu_pkg::WORD_STEP;
          end else begin
            state_nxt = lsu_pkg::st_idle;
            done_nxt = 1'b1;
            base_we_nxt = wb_r;
            base_wdata_nxt = addr_r;
          end
        end
      end
      default: state_nxt = lsu_pkg::st_idle;
    endcase
  end

  // register stage for all sequencer state
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      state_r <= lsu_pkg::st_idle;
      addr_r <= lsu_pkg::ADDR_RESET;
      reg_r <= 4'h0;
      list_r <= 16'h0;
      pair_r <= 1'b0;
      rt2_r <= 4'h0;
      load_r <= 1'b0;
      multi_r <= 1'b0;
      db_r <= 1'b0;
      wb_r <= 1'b0;
      unpriv_r <= 1'b0;
      ty_r <= lsu_pkg::ty_word;
      size_r <= lsu_pkg::SZ_WORD;
      base_reg_r <= 4'h0;
      rf_we_r <= 1'b0;
      rf_waddr_r <= 4'h0;
      rf_wdata_r <= 32'h0;
      branch_r <= 1'b0;
      target_r <= 32'h0;
      base_we_r <= 1'b0;
      base_wdata_r <= 32'h0;
      undef_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      reg_r <= reg_nxt;
      list_r <= list_nxt;
      pair_r <= pair_nxt;
      rt2_r <= rt2_nxt;
      load_r <= load_nxt;
      multi_r <= multi_nxt;
      db_r <= db_nxt;
      wb_r <= wb_nxt;
      unpriv_r <= unpriv_nxt;
      ty_r <= ty_nxt;
      size_r <= size_nxt;
      base_reg_r <= base_reg_nxt;
      rf_we_r <= rf_we_nxt;
      rf_waddr_r <= rf_waddr_nxt;
      rf_wdata_r <= rf_wdata_nxt;
      branch_r <= branch_nxt;
      target_r <= target_nxt;
      base_we_r <= base_we_nxt;
      base_wdata_r <= base_wdata_nxt;
      undef_r <= undef_nxt;
      done_r <= done_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign BUSY = (state_r != lsu_pkg::st_idle);
  assign MEM_REQ = (state_r == lsu_pkg::st_xfer);
  assign MEM_WRITE = ~load_r;
  assign MEM_ADDR = addr_r;
  assign MEM_SIZE = size_r;
  assign MEM_UNPRIV = unpriv_r;
  assign MEM_REG = reg_r;
  assign RF_WE = rf_we_r;
  assign RF_WADDR = rf_waddr_r;
  assign RF_WDATA = rf_wdata_r;
  assign BRANCH = branch_r;
  assign BRANCH_TARGET = target_r;
  assign BASE_WE = base_we_r;
  assign BASE_WADDR = base_reg_r;
  assign BASE_WDATA = base_wdata_r;
  assign FLAGS_WE = 1'b0;
  assign UNDEF = undef_r;
  assign DONE = done_r;

  // ==========================================================
  // assertions
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  logic take; // operation accepted this cycle
  assign take = START && !BUSY && d_legal;
  sequence s_step;
    MEM_REQ && MEM_ACK && multi_r && (list_r != 16'h0);
  endsequence

  a_reg_offset: assert property (
    take && d_regoff |=> MEM_ADDR == $past(BASE_VAL) + ($past(OFFSET_VAL) << $past(SHIFT_AMT)))
    else $error("register-offset address wrong");
  a_zero_ext: assert property (
    MEM_REQ && MEM_ACK && load_r && ty_r == lsu_pkg::ty_byte && reg_r != lsu_pkg::PC_NUM
    |=> RF_WE && RF_WDATA == {24'h0, $past(MEM_RDATA[7:0])})
    else $error("unsigned byte not zero-extended");
  a_sign_ext: assert property (
    RF_WE && $past(ty_r) == lsu_pkg::ty_signed_halfword_type
    |-> RF_WDATA[31:16] == {16{RF_WDATA[15]}})
    else $error("signed halfword not sign-extended");
  a_signed_store: assert property (
    START && !BUSY && !d_load && d_signed |=> UNDEF && !BUSY)
    else $error("signed store was decoded");
  a_branch_even: assert property (
    MEM_REQ && MEM_ACK && load_r && reg_r == lsu_pkg::PC_NUM
    |=> BRANCH && !RF_WE && BRANCH_TARGET == {$past(MEM_RDATA[31:1]), 1'b0})
    else $error("pc load branch wrong");
  a_no_flags: assert property (!FLAGS_WE)
    else $error("flags written");
  a_unpriv_req: assert property (
    take && d_unpriv |=> MEM_REQ && MEM_UNPRIV)
    else $error("unprivileged access shown privileged");
  a_unpriv_range: assert property (
    START && !BUSY && d_unpriv && imm_mag > lsu_pkg::UNPRIV_MAX |=> UNDEF)
    else $error("unprivileged offset over range taken");
  a_pc_addr: assert property (
    take && (d_pcrel || d_pair) |=> MEM_ADDR == $past(PC_VAL) + 32'($signed($past(IMM_OFFSET))))
    else $error("pc-relative address wrong");
  a_multi_word: assert property (MEM_REQ && multi_r |-> MEM_SIZE == lsu_pkg::SZ_WORD)
    else $error("multiple transfer not word sized");
  a_ia_step: assert property (
    (s_step and !db_r) |=> MEM_ADDR == $past(MEM_ADDR) + 32'h4 && MEM_REG > $past(MEM_REG))
    else $error("increment-after step wrong");
  a_db_step: assert property (
    (s_step and db_r) |=> MEM_ADDR == $past(MEM_ADDR) - 32'h4 && MEM_REG < $past(MEM_REG))
    else $error("decrement-before step wrong");
  a_wb_final: assert property (
    BASE_WE |-> DONE && BASE_WDATA == $past(MEM_ADDR) && $past(multi_r))
    else $error("writeback value wrong");
  a_single_no_wb: assert property (
    DONE && !multi_r |-> !BASE_WE)
    else $error("single transfer wrote base");
endmodule
`default_nettype wire

// >>> inc/lsu_pkg.sv
/*
 lsu_pkg: shared opcodes, transfer types, states and constants for the load/store
 address unit. Assumes a 32-bit datapath and sixteen architectural registers.
*/
`default_nettype none
package lsu_pkg;
  // ==========================================================
  // operation codes presented by the instruction front end
  typedef enum logic [3:0] {
    op_load_register = 4'h0, // register-offset load
    op_store_register = 4'h1, // register-offset store
    op_load_register_unpriv = 4'h2, // unprivileged load
    op_store_register_unpriv = 4'h3, // unprivileged store
    op_load_register_pc = 4'h4, // pc-relative single load
    op_load_register_pair = 4'h5, // pc-relative two-word load
    op_load_multiple = 4'h6, // no mode given, increment after
    op_load_multiple_increment_after = 4'h7,
    op_load_multiple_decrement_before = 4'h8,
    op_store_multiple = 4'h9, // no mode given, increment after
    op_store_multiple_increment_after = 4'ha,
    op_store_multiple_decrement_before = 4'hb,
    op_pop_full_descending_alias = 4'hc,
    op_pop_empty_ascending_alias = 4'hd,
    op_push_empty_ascending_alias = 4'he,
    op_push_full_descending_alias = 4'hf
  } opcode_t;
  // ==========================================================
  // transfer types
  typedef enum logic [2:0] {
    ty_word = 3'h0,
    ty_byte = 3'h1,
    ty_signed_byte_type = 3'h2,
    ty_half = 3'h3,
    ty_signed_halfword_type = 3'h4
  } xtype_t;
  // ==========================================================
  // sequencer states, one-hot
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_xfer = 2'b10
  } state_t;
  // ==========================================================
  // access sizes on the data bus
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  // address step between words of a multiple or pair transfer
  localparam logic [31:0] WORD_STEP = 32'h4;
  // offset limits
  localparam logic [12:0] UNPRIV_MAX = 13'h0ff; // 255
  localparam logic [12:0] PC_SINGLE_MAX = 13'h0fff; // 4095
  localparam logic [12:0] PC_PAIR_MAX = 13'h03fc; // 1020
  // register numbers and reset address
  localparam logic [3:0] PC_NUM = 4'hf;
  localparam logic [31:0] ADDR_RESET = 32'h0;
endpackage
`default_nettype wire

// >>> verif/lsu_mem_model.sv
/*
 lsu_mem_model: data-side memory for the load/store unit bench.
 Assumes requests hold until acknowledged; loads come back right aligned.
*/
`default_nettype none
module lsu_mem_model (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic SLOW, // high = two wait cycles per access
  input wire logic MEM_REQ,
  input wire logic [31:0] MEM_ADDR,
  output logic MEM_ACK,
  output logic [31:0] MEM_RDATA
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] wait_r; // wait cycles spent on this request
  logic [31:0] junk_r; // filler while no data is valid
  // ==========================================================
  // wait count; the filler flips every cycle so a stale read never matches
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      wait_r <= 2'h0;
      junk_r <= 32'h5a5a_5a5a;
    end else begin
      wait_r <= (MEM_REQ && !MEM_ACK) ? wait_r + 2'h1 : 2'h0;
      junk_r <= ~junk_r;
    end
  end
  // prompt mode answers within the request cycle
  assign MEM_ACK = MEM_REQ && (!SLOW || wait_r == 2'h2);
  // contents are a fixed function of the address
  assign MEM_RDATA = MEM_ACK ? 32'hf0e1_d2c3 + MEM_ADDR : junk_r;
endmodule
`default_nettype wire

// >>> verif/tb.sv
/*
 tb: self-checking bench for lsu_addr_unit with the memory model at its data side.
 Assumes register file and flags live outside; results are read at the ports.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // stimulus and observed signals
  logic MCLK = 1'b0, RESET = 1'b1, START = 1'b0, PRIV_MODE = 1'b0, WRITEBACK = 1'b0;
  logic SLOW = 1'b0;
  logic [3:0] OPCODE = 4'h0, XFER_REG = 4'h0, XFER_REG2 = 4'h0, BASE_REG = 4'h0;
  logic [2:0] XTYPE = 3'h0;
  logic [31:0] BASE_VAL = 32'h0, OFFSET_VAL = 32'h0, PC_VAL = 32'h0;
  logic [1:0] SHIFT_AMT = 2'h0;
  logic [12:0] IMM_OFFSET = 13'h0;
  logic [15:0] REG_LIST = 16'h0;
  logic MEM_ACK, BUSY, MEM_REQ, MEM_WRITE, MEM_UNPRIV, RF_WE, BRANCH, BASE_WE, FLAGS_WE;
  logic UNDEF, DONE;
  logic [31:0] MEM_RDATA, MEM_ADDR, RF_WDATA, BRANCH_TARGET, BASE_WDATA;
  logic [1:0] MEM_SIZE;
  logic [3:0] MEM_REG, RF_WADDR, BASE_WADDR;
  int errors = 0, checked = 0, nund = 0, nflag = 0;
  logic [31:0] qa[$], qbr[$]; // access addresses, branch targets
  logic [7:0] qm[$]; // {write, unpriv, size, reg} per access
  logic [35:0] qrf[$], qbw[$]; // register and base writes
  logic [12:0] imt[6] = '{13'h0fff, 13'h1001, 13'h1000, 13'h03fc, 13'h1c04, 13'h0400};
  lsu_addr_unit #(.REGS(16)) dut (.MCLK, .RESET, .START, .OPCODE, .XTYPE, .PRIV_MODE,
    .BASE_VAL, .OFFSET_VAL, .PC_VAL, .SHIFT_AMT, .IMM_OFFSET, .XFER_REG, .XFER_REG2,
    .BASE_REG, .REG_LIST, .WRITEBACK, .MEM_ACK, .MEM_RDATA, .BUSY, .MEM_REQ, .MEM_WRITE,
    .MEM_ADDR, .MEM_SIZE, .MEM_UNPRIV, .MEM_REG, .RF_WE, .RF_WADDR, .RF_WDATA, .BRANCH,
    .BRANCH_TARGET, .BASE_WE, .BASE_WADDR, .BASE_WDATA, .FLAGS_WE, .UNDEF, .DONE);
  lsu_mem_model mem (.MCLK, .RESET, .SLOW, .MEM_REQ, .MEM_ADDR, .MEM_ACK, .MEM_RDATA);
  always #12.5 MCLK = ~MCLK;
  // ==========================================================
  // monitor: log every acked access and every result pulse
  always @(posedge MCLK) begin
    if (MEM_REQ === 1'b1 && MEM_ACK === 1'b1) begin
      qa.push_back(MEM_ADDR);
      qm.push_back({MEM_WRITE, MEM_UNPRIV, MEM_SIZE, MEM_REG});
    end
    if (RF_WE === 1'b1) qrf.push_back({RF_WADDR, RF_WDATA});
    if (BRANCH === 1'b1) qbr.push_back(BRANCH_TARGET);
    if (BASE_WE === 1'b1) qbw.push_back({BASE_WADDR, BASE_WDATA});
    if (UNDEF === 1'b1) nund++;
    if (FLAGS_WE !== 1'b0) nflag++;
  end
  // ==========================================================
  // expectations, worked out independently of the design
  function automatic logic [31:0] mem_at(input logic [31:0] a);
    return 32'hf0e1_d2c3 + a;
  endfunction
  function automatic logic [31:0] ext(input logic [2:0] t, input logic [31:0] d);
    case (t)
      lsu_pkg::ty_byte: return {24'h0, d[7:0]};
      lsu_pkg::ty_signed_byte_type: return {{24{d[7]}}, d[7:0]};
      lsu_pkg::ty_half: return {16'h0, d[15:0]};
      lsu_pkg::ty_signed_halfword_type: return {{16{d[15]}}, d[15:0]};
      default: return d;
    endcase
  endfunction
  function automatic logic [1:0] sz(input logic [2:0] t);
    if (t == lsu_pkg::ty_word) return lsu_pkg::SZ_WORD;
    if (t == lsu_pkg::ty_half || t == lsu_pkg::ty_signed_halfword_type) return lsu_pkg::SZ_HALF;
    return lsu_pkg::SZ_BYTE;
  endfunction
  // single compare; an unknown matches only the same unknown in the expected value
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // one operation: START stands only in the start cycle, operands hold until the next op, then wait for done or refusal
  task automatic op(input logic [3:0] o, input logic [2:0] t, input logic pv,
      input logic [31:0] b, input logic [31:0] ov, input logic [1:0] sh,
      input logic [12:0] im, input logic [3:0] xr, input logic [15:0] lst, input logic wb);
    int n;
    qa.delete();
    qm.delete();
    qrf.delete();
    qbr.delete();
    qbw.delete();
    nund = 0;
    nflag = 0;
    n = 0;
    @(posedge MCLK);
    START <= 1'b1;
    OPCODE <= o;
    XTYPE <= t;
    PRIV_MODE <= pv;
    BASE_VAL <= b;
    OFFSET_VAL <= ov;
    PC_VAL <= ov;
    SHIFT_AMT <= sh;
    IMM_OFFSET <= im;
    XFER_REG <= xr;
    XFER_REG2 <= xr + 4'h1;
    BASE_REG <= xr + 4'h4;
    REG_LIST <= lst;
    WRITEBACK <= wb;
    @(posedge MCLK);
    START <= 1'b0;
    do begin
      @(posedge MCLK);
      n++;
    end while (DONE !== 1'b1 && UNDEF !== 1'b1 && n < 40);
    #1;
    chk(36'(n < 40), 36'h1);
    chk(36'(nflag), 36'h0);
    chk(36'(BUSY), 36'h0);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] b, a;
    logic [2:0] t;
    logic [12:0] im;
    logic [3:0] rl[$];
    logic st, db;
    int ri;
    repeat (4) @(posedge MCLK);
    RESET <= 1'b0;
    @(posedge MCLK);
    // register offset loads: every type and shift, negative and positive data
    for (int i = 0; i < 10; i++) begin
      t = 3'(i % 5);
      b = (i < 5) ? 32'h0000_0100 : 32'h0000_3040;
      a = b + ((32'h10 + 32'(i)) << (i % 4));
      op(lsu_pkg::op_load_register, t, i[0], b, 32'h10 + 32'(i), 2'(i % 4), 13'h0, 4'h2,
        16'h0, 1'b1);
      chk(qa[0], a);
      chk(qm[0], {1'b0, ~i[0], sz(t), 4'h2});
      chk(qrf[0], {4'h2, ext(t, mem_at(a))});
      chk(36'(qbw.size()), 36'h0);
    end
    op(lsu_pkg::op_store_register, lsu_pkg::ty_half, 1'b0, 32'h8000, 32'h3, 2'h3, 13'h0,
      4'h2, 16'h0, 1'b0);
    chk(qa[0], 32'h8018);
    chk(qm[0], {1'b1, 1'b1, lsu_pkg::SZ_HALF, 4'h2});
    // signed stores do not exist and are refused
    for (int i = 0; i < 2; i++) begin
      op(lsu_pkg::op_store_register, i ? lsu_pkg::ty_signed_halfword_type :
        lsu_pkg::ty_signed_byte_type, 1'b1, 32'h8000, 32'h0, 2'h0, 13'h0, 4'h2, 16'h0, 1'b0);
      chk(36'(nund), 36'h1);
      chk(36'(qa.size()), 36'h0);
    end
    // word load into the program counter branches with bit zero cleared
    op(lsu_pkg::op_load_register, lsu_pkg::ty_word, 1'b1, 32'h200, 32'h4, 2'h1, 13'h0, 4'hf,
      16'h0, 1'b0);
    chk({qbr[0], 4'(qrf.size())}, {mem_at(32'h208) & ~32'h1, 4'h0});
    // unprivileged forms at the offset limits and beyond
    for (int i = 0; i < 4; i++) begin
      im = (i == 0) ? 13'h0 : (i == 1) ? 13'h0ff : (i == 2) ? 13'h100 : 13'h1fff;
      op(i[0] ? lsu_pkg::op_store_register_unpriv : lsu_pkg::op_load_register_unpriv,
        lsu_pkg::ty_byte, 1'b1, 32'h5000, 32'h0, 2'h0, im, 4'h3, 16'h0, 1'b0);
      chk(36'(nund), 36'(i > 1));
      if (i < 2) chk(qa[0], 32'h5000 + 32'(im));
      if (i < 2) chk(qm[0], {i[0], 1'b1, lsu_pkg::SZ_BYTE, 4'h3});
    end
    // pc-relative single and pair loads at the range edges
    for (int i = 0; i < 6; i++) begin
      a = 32'h0001_0000 + {{19{imt[i][12]}}, imt[i]};
      op(i < 3 ? lsu_pkg::op_load_register_pc : lsu_pkg::op_load_register_pair,
        lsu_pkg::ty_word, 1'b1, 32'h0, 32'h0001_0000, 2'h0, imt[i], 4'h6, 16'h0, 1'b1);
      chk(36'(nund), 36'(i % 3 == 2));
      if (i % 3 != 2) chk(qa[0], a);
      if (i % 3 != 2) chk(qrf[0], {4'h6, mem_at(a)});
      if (i == 3 || i == 4) chk(qa[1], a + 32'h4);
      if (i == 3 || i == 4) chk(qrf[1], {4'h7, mem_at(a + 32'h4)});
      chk(36'(qbw.size()), 36'h0);
    end
    // every multiple opcode and alias; odd opcodes see a slow memory
    b = 32'h0000_4000;
    for (int o = 6; o < 16; o++) begin
      st = (o == 9 || o == 10 || o == 11 || o == 14 || o == 15);
      db = (o == 8 || o == 11 || o == 13 || o == 15);
      SLOW <= o[0];
      rl.delete();
      for (int r = 0; r < 16; r++) begin
        if ((st ? 16'h0c06 : 16'h8c06) & (16'h1 << r)) rl.push_back(4'(r));
      end
      if (db) rl.reverse();
      op(4'(o), lsu_pkg::ty_byte, 1'b1, b, 32'h0, 2'h0, 13'h0, 4'h1,
        st ? 16'h0c06 : 16'h8c06, o[1]);
      ri = 0;
      chk(36'(qa.size()), 36'(rl.size()));
      foreach (rl[k]) begin
        a = db ? b - 32'(4 * k) : b + 32'(4 * k);
        chk(qa[k], a);
        chk(qm[k], {st, 1'b0, lsu_pkg::SZ_WORD, rl[k]});
        if (!st && rl[k] == 4'hf) chk(qbr[0], mem_at(a) & ~32'h1);
        if (!st && rl[k] != 4'hf) chk(qrf[ri++], {rl[k], mem_at(a)});
      end
      chk(36'(qbw.size()), 36'(o[1]));
      if (o[1]) chk(qbw[0], {4'h5, a});
    end
    op(lsu_pkg::op_store_multiple, lsu_pkg::ty_word, 1'b1, b, 32'h0, 2'h0, 13'h0, 4'h1,
      16'h0, 1'b0);
    chk(36'(nund), 36'h1);
    chk(36'(qa.size()), 36'h0);
    final_report();
  end
  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge MCLK);
    errors++;
    final_report();
  end
endmodule
`default_nettype wire
